//--- hw/arop_pkg.sv
// Constants shared by the converter result output port.
// Assumes a 200 MHz system clock and pins that arrive asynchronously.
//
// Notes on behaviour
// [RQ1] Port select low drives upper shared pins as parallel bits, high as serial.
// [RQ2] In serial mode the top four parallel outputs are released.
// [RQ3] Serial data leaves the shift register MSB first with the bit clock.
// [RQ4] Code format select picks straight binary or twos complement output.
// [RQ5] Internal clock: each data bit is stable over both bit clock edges.
// [RQ6] External clock, no invert: data changes on rising edge, read on falling.
// [RQ7] External clock, invert: data changes on falling edge, read on rising.
// [RQ8] Bit clock pin is driven out for internal clock, input for external.
// [RQ9] Internal clock: frame marker asserted from read start while data is valid.
// [RQ10] External clock: read unfinished at next conversion end pulses error flag.
// [RQ11] Busy rises at conversion start, falls once the result is latched.
// [RQ12] Host may use busy falling edge as a data ready event.
// [RQ13] Output bus enabled only while chip select and read are both low.
// [RQ14] External clock edges are ignored unless chip select is low.
// [RQ15] Reset input high resets the port and aborts any conversion.
// [RQ16] Clock source low is master with clock out, high is gated slave.
// [RQ17] Frame marker polarity low gives active high marker, high active low.
// [RQ18] Master read timing high sends previous result during conversion.
// [RQ19] Falling edge on convert start holds the sample and starts conversion.
// [RQ20] Each serial frame carries exactly sixteen bits, one per clock period.

package arop_pkg;

    // Clock and timing figures
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CONV_TIME_NS  = 750;
    localparam int SCLK_QTR_NS   = 10;
    localparam int RDERR_TIME_NS = 40;
    localparam logic [7:0] CONV_CYCLES =
        8'((CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [3:0] QTR_CYCLES =
        4'((SCLK_QTR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [3:0] RDERR_CYCLES =
        4'((RDERR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Result and frame sizes
    localparam int          RESULT_BITS = 16;
    localparam logic [4:0]  FRAME_BITS  = 5'h10;
    localparam logic [4:0]  LAST_BIT    = 5'h0F;
    localparam logic [15:0] RESULT_RST  = 16'h0000;

    // Shared pin positions in serial mode
    localparam int PIN_SDATA = 8;
    localparam int PIN_SCLK  = 9;
    localparam int PIN_FRAME = 10;
    localparam int PIN_RDERR = 11;

    // Index of each input in the synchroniser vector
    localparam int SI_CNV  = 0;
    localparam int SI_CS   = 1;
    localparam int SI_RD   = 2;
    localparam int SI_SCLK = 3;
    localparam int SI_RST  = 4;
    localparam int SI_SER  = 5;
    localparam int SI_FMT  = 6;
    localparam int SI_SRC  = 7;
    localparam int SI_FINV = 8;
    localparam int SI_CINV = 9;
    localparam int SI_RTS  = 10;
    localparam int SI_W    = 11;
    // Start, chip select and read idle high
    localparam logic [SI_W-1:0] SYNC_RST = 11'h007;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01
    } arop_conv_e;

    // Master serial frame states
    typedef enum logic [1:0] {
        SR_IDLE  = 2'b00,
        SR_SHIFT = 2'b01,
        SR_DONE  = 2'b11
    } arop_ser_e;

endpackage : arop_pkg

//--- hw/arop_sync.sv
// Two flip-flop synchroniser for a vector of independent pin levels.
// Assumes every bit is a slow level or a clock far below clk.
`timescale 1ns/1ps
`default_nettype none

module arop_sync
#(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // One pair of flops per bit; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_ff;
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    meta_ff     <= RST_VAL[gi];
                    sync_out[gi] <= RST_VAL[gi];
                end
                else
                begin
                    meta_ff     <= async_in[gi];
                    sync_out[gi] <= meta_ff;
                end
            end
        end
    endgenerate

endmodule : arop_sync
`default_nettype wire

//--- hw/arop_top.sv
// Result output port of a 16-bit converter: busy, parallel and serial port.
// Assumes the conversion core presents its code on core_code in clk domain;
// all pins are asynchronous and are synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module arop_top
    import arop_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        convert_start_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        device_reset_req,
    input  wire logic        port_mode_select,
    input  wire logic        code_format_select,
    input  wire logic        clock_source_select,
    input  wire logic        frame_marker_polarity,
    input  wire logic        bit_clock_invert,
    input  wire logic        read_timing_select,
    input  wire logic        sclk_pin_in,
    input  wire logic [15:0] core_code,
    output logic             busy,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe
);

    // Synchronised pin levels
    logic [SI_W-1:0] pin_s;
    arop_sync #(.WIDTH(SI_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({read_timing_select, bit_clock_invert,
                    frame_marker_polarity, clock_source_select,
                    code_format_select, port_mode_select, device_reset_req,
                    sclk_pin_in, rd_n, cs_n, convert_start_n}),
        .sync_out (pin_s)
    );

    // State
    arop_conv_e  conv_state_ff;
    arop_ser_e   ser_state_ff;
    logic [7:0]  conv_cnt_ff;
    logic        busy_ff;
    logic [15:0] result_ff;
    logic [15:0] shift_ff;
    logic        sout_ff;
    logic [4:0]  bit_cnt_ff;
    logic [3:0]  qtr_div_ff;
    logic [1:0]  qtr_ph_ff;
    logic        fresh_ff;
    logic [3:0]  err_cnt_ff;
    logic        cnv_prev_ff;
    logic        sclk_prev_ff;

    // Decoded pin levels and modes
    wire rst_req    = pin_s[SI_RST];
    wire cs_s       = pin_s[SI_CS];
    wire ser_mode   = pin_s[SI_SER];
    wire slave_sel  = pin_s[SI_SRC];
    wire fmt_s      = pin_s[SI_FMT];
    wire finv_s     = pin_s[SI_FINV];
    wire cinv_s     = pin_s[SI_CINV];
    wire rts_s      = pin_s[SI_RTS];
    wire master_ser = ser_mode & ~slave_sel;
    wire slave_ser  = ser_mode & slave_sel;
    // [RQ13] bus enable gate
    wire bus_en     = ~cs_s & ~pin_s[SI_RD];
    wire par_en     = bus_en & ~ser_mode;
    wire ser_en     = bus_en & ser_mode;

    // Edge detection on the synchronised start and bit clock
    // [RQ19] start on falling edge
    wire cnv_fall   = cnv_prev_ff & ~pin_s[SI_CNV];
    wire sclk_rise  = pin_s[SI_SCLK] & ~sclk_prev_ff;
    wire sclk_fall  = ~pin_s[SI_SCLK] & sclk_prev_ff;
    // [RQ6] [RQ7] active edge per invert
    wire act_edge   = cinv_s ? sclk_fall : sclk_rise;
    // [RQ14] edges count only with chip select low
    wire slv_edge   = slave_ser & ~cs_s & act_edge;

    // Conversion sequencing
    wire conv_idle  = (conv_state_ff == CV_IDLE);
    wire conv_start = cnv_fall & conv_idle & ~rst_req;
    wire conv_end   = (conv_state_ff == CV_RUN) &
                      (conv_cnt_ff == 8'h01) & ~rst_req;
    // [RQ4] offset binary when high, twos complement when low
    wire [15:0] fmt_code = {core_code[15] ^ ~fmt_s, core_code[14:0]};

    // Master frame timing
    wire shifting   = (ser_state_ff == SR_SHIFT);
    wire qtr_tick   = (qtr_div_ff == QTR_CYCLES - 4'h1);
    wire m_bit_end  = shifting & qtr_tick & (qtr_ph_ff == 2'h3);
    wire m_last     = m_bit_end & (bit_cnt_ff == LAST_BIT);
    // [RQ16] [RQ18] master read start conditions
    wire m_start    = master_ser & bus_en & (ser_state_ff == SR_IDLE) &
                      fresh_ff & (rts_s | ~busy_ff) & ~rst_req;

    // Slave shifting and incomplete read detection
    wire slv_shift  = slv_edge & (bit_cnt_ff != FRAME_BITS);
    wire rd_started = (bit_cnt_ff != 5'h00) & (bit_cnt_ff != FRAME_BITS);
    // [RQ10] discard an unfinished slave read
    wire slv_load   = conv_end & slave_ser;
    wire slv_discard = slv_load & rd_started;
    wire err_flag   = (err_cnt_ff != 4'h0);

    // Conversion next state
    arop_conv_e nxt_conv_state;
    logic [7:0] nxt_conv_cnt;
    always_comb
    begin
        nxt_conv_state = conv_state_ff;
        nxt_conv_cnt   = conv_cnt_ff;
        unique case (conv_state_ff)
            CV_IDLE:
            begin
                // [RQ19] begin conversion
                if (conv_start)
                begin
                    nxt_conv_state = CV_RUN;
                    nxt_conv_cnt   = CONV_CYCLES;
                end
            end
            CV_RUN:
            begin
                nxt_conv_cnt = conv_cnt_ff - 8'h01;
                if (conv_end)
                    nxt_conv_state = CV_IDLE;
            end
            default:
            begin
                nxt_conv_state = CV_IDLE;
            end
        endcase
        // [RQ15] reset input aborts conversion
        if (rst_req)
        begin
            nxt_conv_state = CV_IDLE;
            nxt_conv_cnt   = 8'h00;
        end
    end

    // Conversion registers; result latched as busy falls
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            conv_state_ff <= CV_IDLE;
            conv_cnt_ff   <= 8'h00;
            busy_ff       <= 1'b0;
            result_ff     <= RESULT_RST;
            cnv_prev_ff   <= 1'b1;
            sclk_prev_ff  <= 1'b0;
        end
        else
        begin
            conv_state_ff <= nxt_conv_state;
            conv_cnt_ff   <= nxt_conv_cnt;
            // [RQ11] busy follows the running conversion
            busy_ff       <= (nxt_conv_state == CV_RUN);
            result_ff     <= conv_end ? fmt_code : result_ff;
            cnv_prev_ff   <= pin_s[SI_CNV];
            sclk_prev_ff  <= pin_s[SI_SCLK];
        end
    end

    // Master frame next state
    arop_ser_e nxt_ser_state;
    always_comb
    begin
        nxt_ser_state = ser_state_ff;
        unique case (ser_state_ff)
            SR_IDLE:
            begin
                if (m_start)
                    nxt_ser_state = SR_SHIFT;
            end
            SR_SHIFT:
            begin
                // [RQ20] sixteen bits then stop
                if (m_last)
                    nxt_ser_state = SR_DONE;
            end
            SR_DONE:
            begin
                if (!bus_en)
                    nxt_ser_state = SR_IDLE;
            end
            default:
            begin
                nxt_ser_state = SR_IDLE;
            end
        endcase
        if (rst_req || !master_ser)
            nxt_ser_state = SR_IDLE;
    end

    // Shift path selection: reset, slave reload, master load, then shifts
    // [RQ3] MSB first from the shift register
    wire adv      = m_bit_end & ~m_last;
    wire do_shift = adv | slv_shift;
    wire [15:0] nxt_shift =
        rst_req  ? RESULT_RST :
        slv_load ? fmt_code :
        m_start  ? {result_ff[14:0], 1'b0} :
        do_shift ? {shift_ff[14:0], 1'b0} : shift_ff;
    wire nxt_sout =
        rst_req  ? 1'b0 :
        slv_load ? sout_ff :
        m_start  ? result_ff[15] :
        do_shift ? shift_ff[15] : sout_ff;
    wire [4:0] nxt_bit_cnt =
        (rst_req | slv_load | m_start) ? 5'h00 :
        do_shift ? bit_cnt_ff + 5'h01 : bit_cnt_ff;
    // [RQ5] quarter phases keep data still around both clock edges
    wire [3:0] nxt_qtr_div =
        (!shifting || qtr_tick) ? 4'h0 : qtr_div_ff + 4'h1;
    wire [1:0] nxt_qtr_ph =
        !shifting ? 2'h0 : qtr_tick ? qtr_ph_ff + 2'h1 : qtr_ph_ff;
    wire nxt_fresh = conv_end | (fresh_ff & ~m_start & ~rst_req);
    wire [3:0] nxt_err_cnt =
        slv_discard ? RDERR_CYCLES :
        rst_req     ? 4'h0 :
        err_flag    ? err_cnt_ff - 4'h1 : 4'h0;

    // Serial registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ser_state_ff <= SR_IDLE;
            shift_ff     <= RESULT_RST;
            sout_ff      <= 1'b0;
            bit_cnt_ff   <= 5'h00;
            qtr_div_ff   <= 4'h0;
            qtr_ph_ff    <= 2'h0;
            fresh_ff     <= 1'b0;
            err_cnt_ff   <= 4'h0;
        end
        else
        begin
            ser_state_ff <= nxt_ser_state;
            shift_ff     <= nxt_shift;
            sout_ff      <= nxt_sout;
            bit_cnt_ff   <= nxt_bit_cnt;
            qtr_div_ff   <= nxt_qtr_div;
            qtr_ph_ff    <= nxt_qtr_ph;
            fresh_ff     <= nxt_fresh;
            err_cnt_ff   <= nxt_err_cnt;
        end
    end

    // Serial pin functions
    // [RQ9] [RQ17] marker spans the frame, polarity selectable
    wire frame_pin = shifting ^ finv_s;
    wire sclk_int  = shifting & (qtr_ph_ff == 2'h1 | qtr_ph_ff == 2'h2);
    wire sclk_pin  = sclk_int ^ cinv_s;
    wire [15:0] ser_word = {result_ff[15:12], err_flag, frame_pin,
                            sclk_pin, sout_ff, result_ff[7:0]};

    // Pin drive; [RQ1] parallel or serial use of shared pins
    assign busy    = busy_ff;
    assign pin_out = ser_mode ? ser_word : result_ff;
    // [RQ2] [RQ8] upper bits released, clock pin driven only as master
    assign pin_oe  = {{4{par_en}},
                      par_en | (ser_en & slave_sel),
                      par_en | (ser_en & ~slave_sel),
                      par_en | (ser_en & ~slave_sel),
                      par_en | ser_en,
                      {8{par_en}}};

    // Checks on the port behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_par_drive: assert property ( // [RQ1]
        par_en |-> (pin_oe == 16'hFFFF) && (pin_out == result_ff))
        else $error("parallel port not driving the result");
    a_upper_hiz: assert property (ser_mode |-> pin_oe[15:12] == 4'h0) // [RQ2]
        else $error("upper bits driven in serial mode");
    a_msb_first: assert property ( // [RQ3]
        m_start |=> (sout_ff == $past(result_ff[15])) && shifting)
        else $error("frame did not open with the MSB");
    a_code_format: assert property ( // [RQ4]
        conv_end |=> result_ff[15] == ($past(core_code[15]) ^ ~$past(fmt_s)))
        else $error("result format bit wrong");
    a_data_stable: assert property ( // [RQ5]
        shifting && $changed(sout_ff) |-> qtr_ph_ff == 2'h0 && qtr_div_ff == 4'h0)
        else $error("master data moved inside a bit period");
    a_rise_update: assert property ( // [RQ6]
        slave_ser && !cinv_s && sclk_fall && !slv_load && !rst_req
        |=> $stable(bit_cnt_ff) && $stable(sout_ff))
        else $error("slave data moved on a falling edge");
    a_fall_update: assert property ( // [RQ7]
        slave_ser && cinv_s && sclk_rise && !slv_load && !rst_req
        |=> $stable(bit_cnt_ff) && $stable(sout_ff))
        else $error("slave data moved on a rising edge");
    a_clk_pin_dir: assert property (slave_ser |-> !pin_oe[PIN_SCLK]) // [RQ8]
        else $error("clock pin driven in slave mode");
    a_frame_span: assert property ( // [RQ9]
        m_start |=> (pin_out[PIN_FRAME] == ~finv_s)[*8])
        else $error("frame marker not held at read start");
    a_rderr_pulse: assert property ( // [RQ10]
        slv_discard |=> err_flag[*3] ##1 (bit_cnt_ff == 5'h00 || err_flag))
        else $error("incomplete read not flagged");
    a_busy_rise: assert property ( // [RQ11]
        conv_start |=> busy ##[1:200] $fell(busy))
        else $error("busy did not frame the conversion");
    a_busy_latch: assert property ( // [RQ11]
        $fell(busy) && !$past(rst_req) |-> result_ff == $past(fmt_code))
        else $error("busy fell before the result was latched");
    a_bus_gate: assert property (pin_oe != 16'h0000 |-> bus_en) // [RQ13]
        else $error("output driven without chip select and read");
    a_cs_gate: assert property ( // [RQ14]
        slave_ser && cs_s && !slv_load && !rst_req |=> $stable(shift_ff))
        else $error("slave shifted with chip select high");
    a_reset_abort: assert property (rst_req |=> !busy && conv_idle) // [RQ15]
        else $error("reset input did not abort conversion");
    a_master_only: assert property ( // [RQ16]
        shifting |-> !slave_sel || !ser_mode || $past(rst_req))
        else $error("master frame in slave mode");
    a_frame_polar: assert property ( // [RQ17]
        ser_mode |-> pin_out[PIN_FRAME] == (shifting ^ finv_s))
        else $error("frame marker polarity wrong");
    a_read_timing: assert property ( // [RQ18]
        master_ser && !rts_s && busy_ff && !shifting |=> !shifting)
        else $error("master frame started during conversion");
    a_conv_start: assert property ( // [RQ19]
        conv_start |=> conv_cnt_ff == CONV_CYCLES)
        else $error("start edge did not begin a conversion");
    a_frame_bits: assert property ( // [RQ20]
        m_bit_end && bit_cnt_ff == LAST_BIT && master_ser && !rst_req
        |=> ser_state_ff == SR_DONE)
        else $error("master frame length is not sixteen bits");

endmodule : arop_top
`default_nettype wire

//--- verification/arop_host.sv
// Host model: makes the external bit clock and samples serial data.
// Assumes the bench raises go once per frame and waits for done.
`timescale 1ns/1ps
`default_nettype none

module arop_host
(
    input  wire logic       go,
    input  wire logic       inv,
    input  wire logic [4:0] n_edges,
    input  wire logic       sdata,
    output logic            sclk,
    output logic     [15:0] cap,
    output logic            done
);
    // One frame of 80 ns periods; clock stands at idle level between frames
    // host drives clock
    initial
    begin
        sclk = 1'b0;
        cap  = 16'h0000;
        done = 1'b0;
        forever
        begin
            @(posedge go);
            done = 1'b0;
            sclk = inv;
            #40;
            repeat (n_edges)
            begin
                sclk = ~inv;
                #40;
                sclk = inv;
                cap  = {cap[14:0], sdata};
                #40;
            end
            done = 1'b1;
        end
    end
endmodule : arop_host

`default_nettype wire

//--- verification/tb.sv
// Bench for the converter result port: conversions, parallel, serial reads.
// Assumes arop_host makes the external bit clock in slave mode.
`timescale 1ns/1ps
`default_nettype none

module tb
    import arop_pkg::*;
();
    logic        clk, sys_rst, convert_start_n, cs_n, rd_n;
    logic        device_reset_req, port_mode_select, code_format_select;
    logic        clock_source_select, frame_marker_polarity;
    logic        bit_clock_invert, read_timing_select, busy;
    logic [15:0] core_code, pin_out, pin_oe, cap;
    logic        go, sclk, done;
    logic [4:0]  n_edges;
    wire logic   sdata;
    int          n_mismatch, tests_run, ne;

    // Released data line shows the inverse of its last level
    assign sdata = pin_oe[PIN_SDATA] ? pin_out[PIN_SDATA]
                                     : ~pin_out[PIN_SDATA];

    arop_top i_dut (.clk(clk), .sys_rst(sys_rst),
        .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
        .device_reset_req(device_reset_req),
        .port_mode_select(port_mode_select),
        .code_format_select(code_format_select),
        .clock_source_select(clock_source_select),
        .frame_marker_polarity(frame_marker_polarity),
        .bit_clock_invert(bit_clock_invert),
        .read_timing_select(read_timing_select), .sclk_pin_in(sclk),
        .core_code(core_code), .busy(busy), .pin_out(pin_out),
        .pin_oe(pin_oe));

    arop_host i_host (.go(go), .inv(bit_clock_invert), .n_edges(n_edges),
        .sdata(sdata), .sclk(sclk), .cap(cap), .done(done));

    // System clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] fmt(input logic [15:0] c,
                                        input logic sb);
        return sb ? c : {~c[15], c[14:0]};
    endfunction : fmt

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Starts a conversion, retries start while busy, counts busy and flag
    task automatic convert(input logic [15:0] code, output int nerr);
        int len;
        len  = 0;
        nerr = 0;
        repeat (4) @(posedge clk);
        core_code       <= code;
        convert_start_n <= 1'b0;
        repeat (200)
        begin
            @(posedge clk);
            if (len == 20) convert_start_n <= 1'b1;
            if (len == 24) convert_start_n <= 1'b0;
            if (len == 30) convert_start_n <= 1'b1;
            @(negedge clk);
            if (busy === 1'b1) len++;
            if (pin_out[PIN_RDERR] === 1'b1) nerr++;
        end
        check(16'(len), 16'(CONV_CYCLES), "busy length");
    endtask : convert

    task automatic par_read(input logic [15:0] exp);
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (5) @(negedge clk);
        check(pin_oe, 16'h0000, "oe with read high");
        @(posedge clk);
        rd_n <= 1'b0;
        repeat (5) @(negedge clk);
        check(pin_oe, 16'hFFFF, "parallel oe");
        check(pin_out, exp, "parallel data");
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : par_read

    // Master frame: sample at bit clock rise, recheck at its fall
    task automatic mst_read(input logic [15:0] exp, input logic p);
        logic [15:0] got;
        logic        d, prv;
        int          nb;
        got = 16'h0000;
        d   = 1'b0;
        prv = 1'b0;
        nb  = 0;
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (200)
        begin
            @(negedge clk);
            if (pin_out[PIN_FRAME] === ~p)
            begin
                if (prv === 1'b0 && pin_out[PIN_SCLK] === 1'b1)
                begin
                    d   = pin_out[PIN_SDATA];
                    got = {got[14:0], d};
                    nb++;
                end
                if (prv === 1'b1 && pin_out[PIN_SCLK] === 1'b0)
                    check(16'(pin_out[PIN_SDATA]), 16'(d), "bit held");
                if (nb == 8)
                    check(16'(pin_oe[15:8]), 16'h0007, "serial oe");
            end
            prv = pin_out[PIN_SCLK];
        end
        check(got, exp, "master data");
        check(16'(nb), 16'h0010, "master bits");
        check(16'(pin_out[PIN_FRAME]), 16'(p), "marker off");
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : mst_read

    task automatic slv_read(input logic [4:0] n);
        @(posedge clk);
        n_edges <= n;
        go      <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
        go <= 1'b0;
    endtask : slv_read

    // Watchdog against a hang
    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        {sys_rst, convert_start_n, cs_n, rd_n} = 4'hF;
        {device_reset_req, port_mode_select, clock_source_select} = 3'h0;
        {frame_marker_polarity, bit_clock_invert, read_timing_select} = 3'h0;
        code_format_select = 1'b1;
        core_code          = 16'h0000;
        go                 = 1'b0;
        n_edges            = 5'h00;
        n_mismatch         = 0;
        tests_run          = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge clk);
        check(pin_oe, 16'h0000, "oe after reset");
        for (int f = 0; f < 2; f++)
        begin
            @(posedge clk);
            code_format_select <= f[0];
            convert(16'h8001 ^ {16{f[0]}}, ne);
            par_read(fmt(16'h8001 ^ {16{f[0]}}, f[0]));
        end
        $display("test parallel done");
        @(posedge clk);
        convert_start_n <= 1'b0;
        repeat (30) @(negedge clk);
        check(16'(busy), 16'h0001, "busy before abort");
        @(posedge clk);
        device_reset_req <= 1'b1;
        repeat (8) @(negedge clk);
        check(16'(busy), 16'h0000, "busy after abort");
        @(posedge clk);
        device_reset_req <= 1'b0;
        convert_start_n  <= 1'b1;
        $display("test abort done");
        port_mode_select <= 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            frame_marker_polarity <= p[0];
            convert(16'hA5C3 ^ 16'(p), ne);
            mst_read(16'hA5C3 ^ 16'(p), p[0]);
        end
        @(posedge clk);
        read_timing_select <= 1'b1;
        convert(16'h1234, ne);
        // Previous result read out while the next conversion runs
        fork
            convert(16'h5678, ne);
            begin
                repeat (20) @(posedge clk);
                mst_read(16'h1234, 1'b1);
            end
        join
        $display("test master done");
        @(posedge clk);
        clock_source_select <= 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk);
            bit_clock_invert <= v[0];
            convert(16'h3C5A, ne);
            slv_read(5'd3);
            @(posedge clk);
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            slv_read(5'd16);
            check(cap, 16'h3C5A, "slave gated frame");
            convert(16'h5AC3, ne);
            check(16'(ne), 16'h0000, "no error after full read");
            slv_read(5'd5);
            convert(16'hC3A6, ne);
            check(16'(ne), 16'(RDERR_CYCLES), "error pulse");
            slv_read(5'd16);
            check(cap, 16'hC3A6, "slave after discard");
            @(posedge clk);
            cs_n <= 1'b1;
            rd_n <= 1'b1;
        end
        $display("test slave done");
        wrap_up();
    end
endmodule : tb

`default_nettype wire
